// ==== bench/adc_channel_queue_sequencer_bench.sv ====
// self-checking bench of the acquisition sequencer
`timescale 1ns/1ps
module adc_channel_queue_sequencer_bench;
   import adc_seq_pkg::*;
   logic        aclk;
   logic        aresetn   = 1'b0;
   logic [7:0]  awaddr    = 8'h00;
   logic        awvalid   = 1'b0;
   logic [31:0] wdata     = 32'h0;
   logic        wvalid    = 1'b0;
   logic        bready    = 1'b0;
   logic [7:0]  araddr    = 8'h00;
   logic        arvalid   = 1'b0;
   logic        rready    = 1'b0;
   logic        trig_in   = 1'b0;
   logic        res_ready = 1'b0;
   logic [4:0]  lat       = 5'h02;
   logic [15:0] code      = 16'h0000;
   logic        awready, wready, bvalid, arready, rvalid, conv_start, conv_done, res_valid, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata, d;
   logic [15:0] conv_code, res_data;
   logic [1:0]  r;
   q_entry_s    fe_sel;
   logic [8:0]  ent [0:7];
   logic [15:0] exp_q [$];
   logic        im        = 1'b0;
   int          qn = 0, qp = 0, n_start = 0, n_errors = 0, cmp_count = 0, i;

   adc_seq u_dut (.awprot(3'h0), .wstrb(4'hf), .arprot(3'h0), .*);
   conv_model u_conv (.*);

   initial
   begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic expire();
      $display("CHECK FAILED wait expected done seen timeout");
      n_errors++;
      results();
   endtask

   task automatic cmp_reg(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e)
      begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
         n_errors++;
      end
   endtask

   task automatic cmp_smp(input logic [15:0] s);
      logic [15:0] e;
      cmp_count++;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
      if (s !== e)
      begin
         $display("CHECK FAILED sample expected %h seen %h", e, s);
         n_errors++;
      end
   endtask

   function automatic q_entry_s sel_of(input logic [8:0] e);
      q_entry_s s;
      s = q_entry_s'(e);
      if (e[8:7] == 2'h3)
         s.cfg = grounded_single_ended_cfg;
      if (s.cfg == balanced_pair_cfg)
         s.channel[3] = 1'b0;
      return s;
   endfunction

   // write with address and data offered together, response awaited
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      logic ta, tw, dn;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      dn = 1'b0;
      for (int n = 0; n < 50 && !dn; n++)
      begin
         @(negedge aclk);
         ta = awready;
         tw = wready;
         dn = bvalid;
         r  = bresp;
         @(posedge aclk);
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
      end
      bready <= 1'b0;
      if (!dn)
         expire();
      cmp_reg("bresp", 32'(er), 32'(r));
   endtask

   task automatic rd(input logic [7:0] a);
      logic ta, dn;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      dn = 1'b0;
      for (int n = 0; n < 50 && !dn; n++)
      begin
         @(negedge aclk);
         ta = arready;
         dn = rvalid;
         d  = rdata;
         r  = rresp;
         @(posedge aclk);
         if (ta)
            arvalid <= 1'b0;
      end
      rready <= 1'b0;
      if (!dn)
         expire();
   endtask

   // one software conversion, polled, read back and acknowledged
   task automatic conv1(input logic [15:0] c);
      int s0, n;
      s0 = n_start;
      code <= c;
      lat  <= 5'($urandom_range(0, 15));
      wr(OFF_CMD, 32'h1, RESP_OKAY);
      d = 32'h0;
      for (n = 0; n < 100 && !d[0]; n++)
         rd(OFF_STATUS);
      if (!d[0])
         expire();
      cmp_reg("irq", 32'(im), 32'(irq));
      rd(OFF_DATA);
      cmp_smp(d[15:0]);
      cmp_reg("starts", 32'h1, 32'(n_start - s0));
      rd(OFF_STATUS);
      cmp_reg("available", 32'h0, 32'(d[0]));
      wr(OFF_IRQ_STAT, 32'h1, RESP_OKAY);
      cmp_reg("irq", 32'h0, 32'(irq));
   endtask

   always @(negedge aclk)
      if (aresetn)
      begin
         if (conv_start)
         begin
            cmp_reg("fe_sel", 32'(sel_of(ent[qp])), 32'(fe_sel));
            qp = (qn > 0) ? (qp + 1) % qn : 0;
            n_start++;
         end
         if (conv_done)
            exp_q.push_back(conv_code ^ 16'h8000);
         if (res_valid && res_ready)
            cmp_smp(res_data);
      end

   initial
   begin
      i = $urandom(19);
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (ent[k])
      begin
         rd(8'(4 * k));
         cmp_reg("reset value", 32'h0, d);
         cmp_reg("rresp", 32'(RESP_OKAY), 32'(r));
      end
      rd(8'h20);
      cmp_reg("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
      cmp_reg("unmapped rdata", 32'h0, d);
      cmp_reg("irq", 32'h0, 32'(irq));
      $display("test reset values done");
      qn = 5;
      for (i = 0; i < 5; i++)
      begin
         ent[i] = {2'(i), 7'($urandom)};
         if (i == 4)
            ent[i] = ent[1];
         wr(OFF_QENTRY, 32'(ent[i]), RESP_OKAY);
      end
      rd(OFF_QCOUNT);
      cmp_reg("qcount", 32'h5, d);
      im = 1'b1;
      wr(OFF_IRQ_MASK, 32'h1, RESP_OKAY);
      foreach (ent[k])
         conv1(k < 4 ? 16'(64'hffff_0000_8000_7fff >> (k * 16)) : 16'($urandom));
      $display("test software conversions done");
      im = 1'b0;
      wr(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
      wr(OFF_CMD, 32'h2, RESP_OKAY);
      qp = 0;
      qn = 3;
      for (i = 0; i < 3; i++)
      begin
         ent[i] = 9'($urandom);
         wr(OFF_QENTRY, 32'(ent[i]), RESP_OKAY);
      end
      rd(OFF_QCOUNT);
      cmp_reg("qcount", 32'h3, d);
      conv1(16'($urandom));
      $display("test reload done");
      wr(OFF_CTRL, 32'hf, RESP_OKAY);
      n_start = 0;
      trig_in <= 1'b1;
      repeat (30) @(posedge aclk);
      cmp_reg("starts", 32'h0, 32'(n_start));
      trig_in <= 1'b0;
      for (i = 0; i < 400; i++)
      begin
         @(posedge aclk);
         res_ready <= 1'($urandom);
         code      <= 16'($urandom);
         lat       <= 5'($urandom_range(0, 15));
      end
      res_ready <= 1'b1;
      rd(OFF_STATUS);
      cmp_reg("triggered", 32'h1, 32'(d[2]));
      wr(OFF_CTRL, 32'h8, RESP_OKAY);
      repeat (100) @(posedge aclk);
      cmp_reg("left over", 32'h0, 32'(exp_q.size()));
      cmp_reg("started", 32'h1, 32'(n_start > 5));
      $display("test trigger stream done");
      wr(OFF_CMD, 32'h2, RESP_OKAY);
      for (i = 0; i < 513; i++)
         wr(OFF_QENTRY, 32'($urandom) & 32'h1ff, i < 512 ? RESP_OKAY : RESP_SLVERR);
      rd(OFF_QCOUNT);
      cmp_reg("qcount", 32'h200, d);
      $display("test queue limit done");
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFF_QCOUNT);
      cmp_reg("qcount after reset", 32'h0, d);
      rd(OFF_CTRL);
      cmp_reg("ctrl after reset", 32'h0, d);
      // empty queue keeps the first command pending, so the second is refused
      wr(OFF_CMD, 32'h1, RESP_OKAY);
      wr(OFF_CMD, 32'h1, RESP_SLVERR);
      wr(8'h20, 32'h0, RESP_SLVERR);
      $display("test reset and refusals done");
      results();
   end
endmodule // adc_channel_queue_sequencer_bench

// ==== bench/adc_seq_chk.sv ====
// port assertions of the acquisition sequencer
`timescale 1ns/1ps
module adc_seq_chk
   import adc_seq_pkg::*;
(
   // clock and reset
   input wire logic             aclk,
   input wire logic             aresetn,
   // register bus handshakes
   input wire logic             awvalid,
   input wire logic             awready,
   input wire logic             wvalid,
   input wire logic             wready,
   input wire logic             bvalid,
   input wire logic             arvalid,
   input wire logic             arready,
   input wire logic             rvalid,
   input wire logic             rready,
   // front end and stream
   input wire q_entry_s         fe_sel,
   input wire logic             conv_start,
   input wire logic             res_valid,
   input wire logic             res_ready,
   input wire logic [SMP_W-1:0] res_data
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_start_single: assert property (conv_start |=> !conv_start [*8])
      else $error("conv_start pulsed again too soon");
   a_sel_settled: assert property (conv_start |-> $past(fe_sel, 8) == fe_sel)
      else $error("fe_sel moved during settling");
   a_pair_channel: assert property (fe_sel.cfg == balanced_pair_cfg |-> !fe_sel.channel[3])
      else $error("balanced pair with high channel bit");
   a_cfg_known: assert property (fe_sel.cfg != 2'h3)
      else $error("unknown input configuration applied");
   a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
      else $error("write response late");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   a_read_retire: assert property (rvalid && rready |=> !rvalid)
      else $error("read data still offered after it was taken");
   a_res_hold: assert property (res_valid && !res_ready |=> res_valid && $stable(res_data))
      else $error("stream word dropped while stalled");
endmodule // adc_seq_chk

bind adc_seq adc_seq_chk u_chk (.*);

// ==== bench/conv_model.sv ====
// behavioural converter answering start pulses after a set latency
`timescale 1ns/1ps
module conv_model
   import adc_seq_pkg::*;
(
   // clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // converter pins
   input  wire logic             conv_start,
   output logic                  conv_done,
   output logic [SMP_W-1:0]      conv_code,
   // bench controls
   input  wire logic [4:0]       lat,
   input  wire logic [SMP_W-1:0] code
);
   int cnt;

   initial
   begin
      conv_done = 1'b0;
      conv_code = 16'h5a5a;
   end

   always @(posedge aclk)
   begin
      conv_done <= 1'b0;
      // code is only valid with done, so it toggles otherwise
      conv_code <= ~conv_code;
      if (!aresetn)
         cnt = 0;
      else if (conv_start)
         cnt = int'(lat) + 1;
      else if (cnt > 0)
      begin
         cnt = cnt - 1;
         if (cnt == 0)
         begin
            conv_done <= 1'b1;
            conv_code <= code;
         end
      end
   end
endmodule // conv_model

// ==== core/adc_seq.sv ====
// queue-driven acquisition sequencer with axi4-lite registers
`timescale 1ns/1ps
module adc_seq
   import adc_seq_pkg::*;
(
   // clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // axi4-lite write
   input  wire logic [7:0]       awaddr,
   input  wire logic [2:0]       awprot,
   input  wire logic             awvalid,
   output logic                  awready,
   input  wire logic [31:0]      wdata,
   input  wire logic [3:0]       wstrb,
   input  wire logic             wvalid,
   output logic                  wready,
   output logic [1:0]            bresp,
   output logic                  bvalid,
   input  wire logic             bready,
   // axi4-lite read
   input  wire logic [7:0]       araddr,
   input  wire logic [2:0]       arprot,
   input  wire logic             arvalid,
   output logic                  arready,
   output logic [31:0]           rdata,
   output logic [1:0]            rresp,
   output logic                  rvalid,
   input  wire logic             rready,
   // front end and converter
   output q_entry_s              fe_sel,
   output logic                  conv_start,
   input  wire logic             conv_done,
   input  wire logic [SMP_W-1:0] conv_code,
   input  wire logic             trig_in,
   // sample stream to host memory
   output logic                  res_valid,
   output logic [SMP_W-1:0]      res_data,
   input  wire logic             res_ready,
   // interrupt
   output logic                  irq
);
   typedef struct packed
   {
      logic              aw_full;
      logic [7:0]        aw_addr;
      logic              w_full;
      logic [31:0]       w_data;
      logic [3:0]        w_strb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic [3:0]        ctrl;
      logic [QCNT_W-1:0] qlen;
      logic [QIDX_W-1:0] rptr;
      logic              pending;
      logic              triggered;
      logic              trig_d;
      seq_e              state;
      logic [3:0]        cnt;
      q_entry_s          fe;
      logic              start;
      logic [SMP_W-1:0]  result;
      logic [EV_W-1:0]   irq_stat;
      logic [EV_W-1:0]   irq_mask;
   } st_s;

   st_s               r_reg;
   st_s               r_next;
   q_entry_s          q_rd;
   logic              q_we;
   q_entry_s          q_wdata;
   logic              f_ready;
   logic              f_valid;
   logic              f_pop;
   logic              f_push;
   logic [SMP_W-1:0]  f_data;
   logic [FLVL_W-1:0] f_lvl;
   logic              wr_go;
   logic              reg_pop;
   logic              trig_edge;
   logic              want;
   logic [EV_W-1:0]   ev;
   logic [EV_W-1:0]   clr;
   logic [QCNT_W-1:0] rp_inc;
   logic              mode_trig;

   entry_queue u_queue
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .wr_en   (q_we),
      .wr_idx  (r_reg.qlen[QIDX_W-1:0]),
      .wr_data (q_wdata),
      .rd_idx  (r_reg.rptr),
      .rd_data (q_rd)
   );

   result_fifo u_fifo
   (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_valid  (f_push),
      .in_ready  (f_ready),
      .in_data   (r_reg.result),
      .out_valid (f_valid),
      .out_pop   (f_pop),
      .out_data  (f_data),
      .level     (f_lvl)
   );

   assign awready    = !r_reg.aw_full;
   assign wready     = !r_reg.w_full;
   assign bvalid     = r_reg.bvalid;
   assign bresp      = r_reg.bresp;
   assign arready    = !r_reg.rvalid;
   assign rvalid     = r_reg.rvalid;
   assign rdata      = r_reg.rdata;
   assign rresp      = r_reg.rresp;
   assign fe_sel     = r_reg.fe;
   assign conv_start = r_reg.start;
   assign mode_trig  = r_reg.ctrl[CTRL_MODE];
   // in dma mode the stream drains the fifo, otherwise register reads do
   assign res_valid  = r_reg.ctrl[CTRL_DMA] && f_valid;
   assign res_data   = f_data;
   assign reg_pop    = arvalid && arready && (araddr == OFF_DATA)
                       && !r_reg.ctrl[CTRL_DMA];
   assign f_pop      = r_reg.ctrl[CTRL_DMA] ? res_ready : reg_pop;
   assign f_push     = (r_reg.state == S_STORE) && f_ready;
   assign irq        = |(r_reg.irq_stat & r_reg.irq_mask);

   always_comb
   begin
      r_next    = r_reg;
      q_we      = 1'b0;
      q_wdata   = q_entry_s'(r_reg.w_data[8:0]);
      ev        = '0;
      clr       = '0;
      rp_inc    = {1'b0, r_reg.rptr} + 1'b1;
      r_next.start  = 1'b0;
      r_next.trig_d = trig_in;
      trig_edge = r_reg.ctrl[CTRL_FALL] ? (r_reg.trig_d && !trig_in)
                                        : (!r_reg.trig_d && trig_in);
      // trigger only counts while armed in triggered mode
      if (mode_trig && r_reg.ctrl[CTRL_ARM] && !r_reg.triggered && trig_edge)
      begin
         r_next.triggered = 1'b1;
         ev[EV_TRIG]      = 1'b1;
      end
      if (!r_reg.ctrl[CTRL_ARM] || !mode_trig)
         r_next.triggered = 1'b0;
      want = (r_reg.qlen != '0) && (mode_trig ? r_reg.triggered : r_reg.pending);

      unique case (r_reg.state)
         S_IDLE:
         begin
            if (want)
            begin
               r_next.fe = q_rd;
               if (q_rd.cfg == balanced_pair_cfg)
                  r_next.fe.channel = {1'b0, q_rd.channel[2:0]};
               else if (q_rd.cfg != floating_single_ended_cfg)
                  r_next.fe.cfg = grounded_single_ended_cfg;
               r_next.cnt     = SETTLE_CNT;
               r_next.state   = S_SETUP;
               r_next.pending = 1'b0;
            end
         end
         S_SETUP:
         begin
            // front end settles on the new entry before the converter starts
            r_next.cnt = r_reg.cnt - 1'b1;
            if (r_reg.cnt == 4'h1)
            begin
               r_next.start = 1'b1;
               r_next.state = S_CONV;
            end
         end
         S_CONV:
         begin
            if (conv_done)
            begin
               // converter gives offset binary; msb flip gives two's complement
               r_next.result = {~conv_code[SMP_W-1], conv_code[SMP_W-2:0]};
               r_next.state  = S_STORE;
               if (rp_inc >= r_reg.qlen)
                  r_next.rptr = '0;
               else
                  r_next.rptr = rp_inc[QIDX_W-1:0];
            end
         end
         S_STORE:
         begin
            // a full fifo stalls the sequence instead of losing the sample
            if (f_ready)
            begin
               ev[EV_DONE]  = 1'b1;
               r_next.state = S_IDLE;
            end
            else
               ev[EV_STALL] = 1'b1;
         end
      endcase

      // write channel: address and data taken in either order
      if (awvalid && !r_reg.aw_full)
      begin
         r_next.aw_full = 1'b1;
         r_next.aw_addr = awaddr;
      end
      if (wvalid && !r_reg.w_full)
      begin
         r_next.w_full = 1'b1;
         r_next.w_data = wdata;
         r_next.w_strb = wstrb;
      end
      if (r_reg.bvalid && bready)
         r_next.bvalid = 1'b0;
      wr_go = r_reg.aw_full && r_reg.w_full && !r_reg.bvalid;
      if (wr_go)
      begin
         r_next.aw_full = 1'b0;
         r_next.w_full  = 1'b0;
         r_next.bvalid  = 1'b1;
         r_next.bresp   = RESP_OKAY;
         unique case (r_reg.aw_addr)
            OFF_CTRL:
               if (r_reg.w_strb[0])
                  r_next.ctrl = r_reg.w_data[3:0];
            OFF_CMD:
               if (r_reg.w_strb[0])
               begin
                  if (r_reg.w_data[CMD_RELOAD])
                  begin
                     r_next.qlen = '0;
                     r_next.rptr = '0;
                  end
                  if (r_reg.w_data[CMD_CONV] && !mode_trig)
                  begin
                     // a second command before the first starts is refused
                     if (r_reg.pending)
                        r_next.bresp = RESP_SLVERR;
                     else
                        r_next.pending = 1'b1;
                  end
               end
            OFF_QENTRY:
               if (r_reg.qlen < QCNT_W'(QDEPTH) && (&r_reg.w_strb[1:0]))
               begin
                  q_we        = 1'b1;
                  r_next.qlen = r_reg.qlen + 1'b1;
               end
               else
                  r_next.bresp = RESP_SLVERR;
            OFF_IRQ_STAT:
               if (r_reg.w_strb[0])
                  clr = r_reg.w_data[EV_W-1:0];
            OFF_IRQ_MASK:
               if (r_reg.w_strb[0])
                  r_next.irq_mask = r_reg.w_data[EV_W-1:0];
            OFF_QCOUNT, OFF_STATUS, OFF_DATA: ;
            default:
               r_next.bresp = RESP_SLVERR;
         endcase
      end
      // set wins over a clear in the same cycle
      r_next.irq_stat = (r_reg.irq_stat & ~clr) | ev;

      // read channel
      if (r_reg.rvalid && rready)
         r_next.rvalid = 1'b0;
      if (arvalid && !r_reg.rvalid)
      begin
         r_next.rvalid = 1'b1;
         r_next.rresp  = RESP_OKAY;
         r_next.rdata  = '0;
         unique case (araddr)
            OFF_CTRL:     r_next.rdata[3:0] = r_reg.ctrl;
            OFF_CMD, OFF_QENTRY: ;
            OFF_QCOUNT:
            begin
               r_next.rdata[QCNT_W-1:0] = r_reg.qlen;
               r_next.rdata[24:16]      = r_reg.rptr;
            end
            OFF_STATUS:
               r_next.rdata[7:0] = {f_lvl, !f_ready, r_reg.triggered,
                                    r_reg.state != S_IDLE, f_valid};
            OFF_DATA:
               if (!r_reg.ctrl[CTRL_DMA] && f_valid)
                  r_next.rdata[SMP_W-1:0] = f_data;
            OFF_IRQ_STAT: r_next.rdata[EV_W-1:0] = r_reg.irq_stat;
            OFF_IRQ_MASK: r_next.rdata[EV_W-1:0] = r_reg.irq_mask;
            default:      r_next.rresp = RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         r_reg       <= '0;
         r_reg.state <= S_IDLE;
      end
      else
         r_reg <= r_next;
   end
endmodule // adc_seq

// ==== core/adc_seq_pkg.sv ====
// shared constants, types and register map of the acquisition sequencer
package adc_seq_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_CMD      = 8'h04;
   localparam logic [7:0] OFF_QENTRY   = 8'h08;
   localparam logic [7:0] OFF_QCOUNT   = 8'h0c;
   localparam logic [7:0] OFF_STATUS   = 8'h10;
   localparam logic [7:0] OFF_DATA     = 8'h14;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
   // control bits
   localparam int CTRL_MODE = 0;
   localparam int CTRL_ARM  = 1;
   localparam int CTRL_FALL = 2;
   localparam int CTRL_DMA  = 3;
   // command bits
   localparam int CMD_CONV   = 0;
   localparam int CMD_RELOAD = 1;
   // event bits
   localparam int EV_DONE  = 0;
   localparam int EV_TRIG  = 1;
   localparam int EV_STALL = 2;
   localparam int EV_W     = 3;
   // sizes
   localparam int QDEPTH  = 512;
   localparam int QIDX_W  = 9;
   localparam int QCNT_W  = 10;
   localparam int FDEPTH  = 8;
   localparam int FIDX_W  = 3;
   localparam int FLVL_W  = 4;
   localparam int SMP_W   = 16;
   // front end settling time before each conversion
   localparam int CLK_MHZ    = 10;
   localparam int SETTLE_NS  = 1000;
   localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [3:0] SETTLE_CNT = 4'(SETTLE_CYC);
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0]
   {
      grounded_single_ended_cfg = 2'h0,
      floating_single_ended_cfg = 2'h1,
      balanced_pair_cfg         = 2'h2
   } in_cfg_e;

   typedef struct packed
   {
      in_cfg_e    cfg;
      logic       unipolar;
      logic [1:0] gain;
      logic [3:0] channel;
   } q_entry_s;

   typedef enum logic [3:0]
   {
      S_IDLE  = 4'b0001,
      S_SETUP = 4'b0010,
      S_CONV  = 4'b0100,
      S_STORE = 4'b1000
   } seq_e;
endpackage

// ==== core/entry_queue.sv ====
// flip-flop store of the channel queue entries
`timescale 1ns/1ps
module entry_queue
   import adc_seq_pkg::*;
(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // write port
   input  wire logic              wr_en,
   input  wire logic [QIDX_W-1:0] wr_idx,
   input  wire q_entry_s          wr_data,
   // read port
   input  wire logic [QIDX_W-1:0] rd_idx,
   output q_entry_s               rd_data
);
   typedef struct packed
   {
      q_entry_s [QDEPTH-1:0] mem;
   } qst_s;

   qst_s r_reg;
   qst_s r_next;

   always_comb
   begin
      r_next = r_reg;
      if (wr_en)
      begin
         r_next.mem[wr_idx] = wr_data;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         r_reg <= '0;
      else
         r_reg <= r_next;
   end

   assign rd_data = r_reg.mem[rd_idx];
endmodule // entry_queue

// ==== core/result_fifo.sv ====
// sample fifo between the converter and the host
`timescale 1ns/1ps
module result_fifo
   import adc_seq_pkg::*;
(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // fill side
   input  wire logic              in_valid,
   output logic                   in_ready,
   input  wire logic [SMP_W-1:0]  in_data,
   // drain side
   output logic                   out_valid,
   input  wire logic              out_pop,
   output logic [SMP_W-1:0]       out_data,
   output logic [FLVL_W-1:0]      level
);
   typedef struct packed
   {
      logic [FDEPTH-1:0][SMP_W-1:0] mem;
      logic [FIDX_W-1:0]            wptr;
      logic [FIDX_W-1:0]            rptr;
      logic [FLVL_W-1:0]            cnt;
   } fst_s;

   fst_s r_reg;
   fst_s r_next;
   logic push;
   logic pop;

   assign in_ready  = (r_reg.cnt != FLVL_W'(FDEPTH));
   assign out_valid = (r_reg.cnt != '0);
   assign out_data  = r_reg.mem[r_reg.rptr];
   assign level     = r_reg.cnt;

   always_comb
   begin
      r_next = r_reg;
      push   = in_valid && in_ready;
      pop    = out_pop && out_valid;
      if (push)
      begin
         r_next.mem[r_reg.wptr] = in_data;
         r_next.wptr            = r_reg.wptr + 1'b1;
      end
      if (pop)
         r_next.rptr = r_reg.rptr + 1'b1;
      if (push && !pop)
         r_next.cnt = r_reg.cnt + 1'b1;
      else if (pop && !push)
         r_next.cnt = r_reg.cnt - 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         r_reg <= '0;
      else
         r_reg <= r_next;
   end
endmodule // result_fifo
